//--- rtl/dlfc_top.v
// Notes on behaviour
// - high voltage with enable kills high-side drivers
// - high-side stays off until control rewrite after
// - high-side may run in sleep/stop
// - each low driver has enable bit
// - enable plus mod select follows modulation pin
// - open-load flags per low driver
// - current-limit flags per low driver
// - low over-temp kills lows, latches, reports source
// - low over-temp irq only when masked in
// - lows off until control rewrite after cooling
// - high voltage kills lows, rewrite re-enables
// - lows off in sleep and stop
// - two-bit slew field, reset 20 kbit
// - pull-up enable clear disconnects pull-up in sleep/stop, threshold
// - over-current flags, sets receive-only in normal mode, irq
// - over-temp disables transmitter until cool, txd high
// - rx short disables transmitter, read clears flag
// - txd stuck dominant one second disables transmitter
// - stuck-dominant irq only when masked in
// - dominant level select bit
// - receive-only disables transmitter, set on error
// - stop-mode bus wake gives interrupt source
// - sleep-mode bus wake gives reset request
// - low control layout mod2 mod1 en2 en1
// - bus control layout dominant_level_select receive_only_bit slew
// - bus status layout short stuck ot oc
`include "dlfc_map.vh"
module dlfc_top #(
    parameter STUCK_CYC = `DLFC_STUCK_CYC,
    parameter WAKE_CYC  = `DLFC_WAKE_CYC
) (
    // clock and reset
    input  wire       sys_clk_i,
    input  wire       rst_i,
    // register write/read strobes
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire [3:0] addr_i,
    input  wire [3:0] wdata_i,
    output reg  [3:0] rdata_o,
    // mode and analog conditions
    input  wire [1:0] op_mode_i,
    input  wire       high_voltage_i,
    input  wire       low_overtemp_i,
    input  wire       high_overtemp_i,
    input  wire [1:0] low_open_load_i,
    input  wire [1:0] low_current_limit_i,
    input  wire       bus_overcurrent_i,
    input  wire       bus_overtemp_i,
    input  wire       rx_short_i,
    // pins
    input  wire       direct_modulation_input_i,
    input  wire       txd_i,
    input  wire       rxd_i,
    input  wire       bus_level_i,
    // driver controls
    output reg        low_driver_one_o,
    output reg        low_driver_two_o,
    output reg        high_driver_one_o,
    output reg        high_driver_two_o,
    output reg        tx_enable_o,
    output reg  [1:0] slew_rate_field_o,
    output reg        dominant_level_select_o,
    output reg        bus_pullup_o,
    output reg        bus_wake_threshold_o,
    output reg        irq_o,
    output reg        wake_reset_o
);
    reg  [3:0]  mode_control_reg;
    reg  [3:0]  bus_control_reg;
    reg  [3:0]  high_side_control_reg;
    reg  [3:0]  low_side_control_reg;
    reg  [3:0]  interrupt_mask_reg;
    reg  [3:0]  bus_status_reg;
    reg         low_ot_latch_reg;
    reg         high_ot_latch_reg;
    reg         low_off_reg;
    reg         high_off_reg;
    reg         tx_off_reg;
    reg         lin_wake_reg;
    reg         rxd_prev_reg;
    reg         bus_prev_reg;
    reg  [31:0] stuck_cnt_reg;
    reg  [31:0] wake_cnt_reg;
    reg         wake_armed_reg;
    wire        pwm_sync;
    wire        hv_kill;
    wire        low_power;
    wire        wr_low;
    wire        wr_high;
    wire        rd_bus;
    wire        stuck_hit;
    wire        rx_toggle;
    wire        bus_rise;
    wire [3:0]  bus_status_next;
    wire [3:0]  low_stat;
    wire [3:0]  isrc;
    wire        lin_any;
    wire [3:0]  flag_set;
    wire [3:0]  flag_clr;
    wire        stop_mode;
    wire        sleep_mode;
    wire        rd_isrc;
    wire [1:0]  low_gate;
    wire [1:0]  high_gate;
    genvar      gi;

    dlfc_sync u_pwm_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       (direct_modulation_input_i),
        .q_o       (pwm_sync)
    );

    assign hv_kill   = high_voltage_i & mode_control_reg[`DLFC_MODE_HV_SHUTDOWN_ENABLE_BIT];
    assign stop_mode  = (op_mode_i == `DLFC_MODE_STOP);
    assign sleep_mode = (op_mode_i == `DLFC_MODE_SLEEP);
    assign low_power = stop_mode | sleep_mode;
    assign wr_low    = wr_i & (addr_i == `DLFC_ADDR_LOWCTL);
    assign wr_high   = wr_i & (addr_i == `DLFC_ADDR_HIGHCTL);
    assign rd_bus    = rd_i & ((addr_i == `DLFC_ADDR_BUSSTAT) | (addr_i == `DLFC_ADDR_BUSCTL));
    assign rd_isrc   = rd_i & (addr_i == `DLFC_ADDR_ISRC);
    assign stuck_hit = (stuck_cnt_reg >= STUCK_CYC);
    assign rx_toggle = rxd_i ^ rxd_prev_reg;
    assign bus_rise  = bus_level_i & ~bus_prev_reg;
    assign lin_any   = |bus_status_reg;

    // status: per-flag set and read-clear terms
    assign flag_set[`DLFC_BS_OC_BIT]  = bus_overcurrent_i;
    assign flag_set[`DLFC_BS_OT_BIT]  = bus_overtemp_i;
    assign flag_set[`DLFC_BS_TXD_BIT] = stuck_hit;
    assign flag_set[`DLFC_BS_RXS_BIT] = rx_short_i;
    assign flag_clr[`DLFC_BS_OC_BIT]  = rd_bus;
    assign flag_clr[`DLFC_BS_OT_BIT]  = rd_bus & txd_i;
    assign flag_clr[`DLFC_BS_TXD_BIT] = rd_bus & txd_i;
    assign flag_clr[`DLFC_BS_RXS_BIT] = rd_bus;

    // hardware set wins over read clear
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
            assign bus_status_next[gi] = flag_set[gi] | (bus_status_reg[gi] & ~flag_clr[gi]);
        end
    endgenerate

    // thermal shutdown shows as all open-load and limit bits
    assign low_stat = low_ot_latch_reg ? 4'hf :
        {low_open_load_i[1], low_current_limit_i[1], low_open_load_i[0], low_current_limit_i[0]};
    assign isrc = {high_ot_latch_reg, low_ot_latch_reg, lin_any, lin_wake_reg};

    // per driver: enable bit, optionally gated by the synced pin
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_drv
            assign low_gate[gi]  = low_side_control_reg[gi] &
                (~low_side_control_reg[gi+2] | pwm_sync);
            assign high_gate[gi] = high_side_control_reg[gi] &
                (~high_side_control_reg[gi+2] | pwm_sync);
        end
    endgenerate

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_control_reg      <= `DLFC_RST_MODE;
            bus_control_reg       <= `DLFC_RST_BUSCTL;
            high_side_control_reg <= `DLFC_RST_CTL;
            low_side_control_reg  <= `DLFC_RST_CTL;
            interrupt_mask_reg    <= `DLFC_RST_IMASK;
        end else if (wr_i) begin
            case (addr_i)
                `DLFC_ADDR_MODE:    mode_control_reg      <= wdata_i;
                `DLFC_ADDR_BUSCTL:  bus_control_reg       <= wdata_i;
                `DLFC_ADDR_HIGHCTL: high_side_control_reg <= wdata_i;
                `DLFC_ADDR_LOWCTL:  low_side_control_reg  <= wdata_i;
                `DLFC_ADDR_IMASK:   interrupt_mask_reg    <= wdata_i;
                default: ;
            endcase
        end else if ((|bus_status_reg) & (op_mode_i == `DLFC_MODE_NORMAL)) begin
            bus_control_reg[`DLFC_BC_RXO_BIT] <= 1'b1;
        end
    end

    // shutdown latches: released only by control rewrite once clear
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_ot_latch_reg  <= 1'b0;
            high_ot_latch_reg <= 1'b0;
            low_off_reg       <= 1'b0;
            high_off_reg      <= 1'b0;
        end else begin
            if (low_overtemp_i | hv_kill) begin
                low_off_reg <= 1'b1;
            end else if (wr_low) begin
                low_off_reg <= 1'b0;
            end
            if (low_overtemp_i) begin
                low_ot_latch_reg <= 1'b1;
            end else if (wr_low) begin
                low_ot_latch_reg <= 1'b0;
            end
            if (high_overtemp_i | hv_kill) begin
                high_off_reg <= 1'b1;
            end else if (wr_high) begin
                high_off_reg <= 1'b0;
            end
            if (high_overtemp_i) begin
                high_ot_latch_reg <= 1'b1;
            end else if (wr_high) begin
                high_ot_latch_reg <= 1'b0;
            end
        end
    end

    // transmitter faults and stuck-dominant timer
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus_status_reg <= 4'h0;
            stuck_cnt_reg  <= 32'h0;
            tx_off_reg     <= 1'b0;
            rxd_prev_reg   <= 1'b1;
        end else begin
            bus_status_reg <= bus_status_next;
            rxd_prev_reg   <= rxd_i;
            if (txd_i) begin
                stuck_cnt_reg <= 32'h0;
            end else if (!stuck_hit) begin
                stuck_cnt_reg <= stuck_cnt_reg + 32'h1;
            end
            if (bus_overtemp_i | rx_short_i | stuck_hit) begin
                tx_off_reg <= 1'b1;
            end else if (txd_i & (rx_toggle | ~bus_status_reg[`DLFC_BS_RXS_BIT])) begin
                tx_off_reg <= 1'b0;
            end
        end
    end

    // bus wake: dominant longer than filter then rising edge
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wake_cnt_reg   <= 32'h0;
            wake_armed_reg <= 1'b0;
            lin_wake_reg   <= 1'b0;
            bus_prev_reg   <= 1'b1;
        end else begin
            bus_prev_reg <= bus_level_i;
            if (!low_power || bus_control_reg[`DLFC_BC_RXO_BIT] || bus_level_i) begin
                wake_cnt_reg <= 32'h0;
            end else if (wake_cnt_reg < WAKE_CYC) begin
                wake_cnt_reg <= wake_cnt_reg + 32'h1;
            end else begin
                wake_armed_reg <= 1'b1;
            end
            // an arm left from an earlier low-power stay must not fire later
            if (bus_rise | ~low_power | bus_control_reg[`DLFC_BC_RXO_BIT]) begin
                wake_armed_reg <= 1'b0;
            end
            if (bus_rise & wake_armed_reg & low_power) begin
                lin_wake_reg <= 1'b1;
            end else if (rd_isrc) begin
                lin_wake_reg <= 1'b0;
            end
        end
    end

    // registered outputs
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_driver_one_o        <= 1'b0;
            low_driver_two_o        <= 1'b0;
            high_driver_one_o       <= 1'b0;
            high_driver_two_o       <= 1'b0;
            tx_enable_o             <= 1'b0;
            slew_rate_field_o       <= `DLFC_SLEW_20K;
            dominant_level_select_o <= 1'b0;
            bus_pullup_o            <= 1'b1;
            bus_wake_threshold_o    <= 1'b1;
            irq_o                   <= 1'b0;
            wake_reset_o            <= 1'b0;
            rdata_o                 <= 4'h0;
        end else begin
            low_driver_one_o  <= ~low_off_reg & ~low_power & low_gate[0];
            low_driver_two_o  <= ~low_off_reg & ~low_power & low_gate[1];
            high_driver_one_o <= ~high_off_reg & high_gate[0];
            high_driver_two_o <= ~high_off_reg & high_gate[1];
            tx_enable_o <= ~tx_off_reg & ~low_power & ~bus_control_reg[`DLFC_BC_RXO_BIT];
            slew_rate_field_o       <= bus_control_reg[1:0];
            dominant_level_select_o <= bus_control_reg[`DLFC_BC_DOMINANT_LEVEL_SELECT_BIT];
            bus_pullup_o <= ~low_power | mode_control_reg[`DLFC_MODE_PUE_BIT];
            bus_wake_threshold_o <= mode_control_reg[`DLFC_MODE_PUE_BIT];
            irq_o <= (low_ot_latch_reg & interrupt_mask_reg[`DLFC_IM_LS_BIT]) |
                (high_ot_latch_reg & interrupt_mask_reg[`DLFC_IM_HS_BIT]) |
                (lin_any & interrupt_mask_reg[`DLFC_IM_LIN_BIT]) |
                (lin_wake_reg & stop_mode);
            wake_reset_o <= lin_wake_reg & sleep_mode;
            case (addr_i)
                `DLFC_ADDR_BUSCTL,
                `DLFC_ADDR_BUSSTAT: rdata_o <= bus_status_reg;
                `DLFC_ADDR_LOWCTL,
                `DLFC_ADDR_LOWSTAT: rdata_o <= low_stat;
                `DLFC_ADDR_IMASK,
                `DLFC_ADDR_ISRC:    rdata_o <= isrc;
                default:            rdata_o <= 4'h0;
            endcase
        end
    end
endmodule

//--- rtl/dlfc_map.vh
`ifndef DLFC_MAP_VH
`define DLFC_MAP_VH
// register addresses (4-bit)
`define DLFC_ADDR_MODE      4'h0
`define DLFC_ADDR_BUSCTL    4'h4
`define DLFC_ADDR_BUSSTAT   4'h5
`define DLFC_ADDR_HIGHCTL   4'h6
`define DLFC_ADDR_LOWCTL    4'h8
`define DLFC_ADDR_LOWSTAT   4'h9
`define DLFC_ADDR_IMASK     4'he
`define DLFC_ADDR_ISRC      4'hf
// mode control fields
`define DLFC_MODE_HV_SHUTDOWN_ENABLE_BIT  3
`define DLFC_MODE_PUE_BIT   2
// bus control fields
`define DLFC_BC_DOMINANT_LEVEL_SELECT_BIT    3
`define DLFC_BC_RXO_BIT     2
`define DLFC_BC_SLEW_LSB    0
// bus status fields
`define DLFC_BS_RXS_BIT     3
`define DLFC_BS_TXD_BIT     2
`define DLFC_BS_OT_BIT      1
`define DLFC_BS_OC_BIT      0
// interrupt mask fields
`define DLFC_IM_HS_BIT      3
`define DLFC_IM_LS_BIT      2
`define DLFC_IM_LIN_BIT     1
// reset values
`define DLFC_RST_MODE       4'hc
`define DLFC_RST_BUSCTL     4'h1
`define DLFC_RST_CTL        4'h0
`define DLFC_RST_IMASK      4'h0
// slew settings
`define DLFC_SLEW_10K4      2'h0
`define DLFC_SLEW_20K       2'h1
`define DLFC_SLEW_FAST      2'h2
// operating modes
`define DLFC_MODE_NORMAL    2'h0
`define DLFC_MODE_STOP      2'h1
`define DLFC_MODE_SLEEP     2'h2
// timing
`define DLFC_CLK_HZ         100000000
`define DLFC_STUCK_MS       1000
`define DLFC_STUCK_CYC      (`DLFC_CLK_HZ / 1000 * `DLFC_STUCK_MS)
`define DLFC_WAKE_NS        50000
`define DLFC_WAKE_CYC       ((`DLFC_WAKE_NS + 9) / 10)
`endif

//--- rtl/dlfc_sync.v
module dlfc_sync (
    // clock and reset
    input  wire sys_clk_i,
    input  wire rst_i,
    // async level in, synced level out
    input  wire d_i,
    output wire q_o
);
    reg meta_reg;
    reg sync_reg;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule

//--- test/dlfc_props.sv
module dlfc_props #(
    parameter STUCK_CYC = 50,
    parameter WAKE_CYC  = 5
) (
    input wire       sys_clk_i,
    input wire       rst_i,
    input wire       wr_i,
    input wire [3:0] addr_i,
    input wire [3:0] wdata_i,
    input wire [1:0] op_mode_i,
    input wire       high_voltage_i,
    input wire       low_overtemp_i,
    input wire       direct_modulation_input_i,
    input wire       txd_i,
    input wire       low_driver_one_o,
    input wire       low_driver_two_o,
    input wire       high_driver_one_o,
    input wire       high_driver_two_o,
    input wire       tx_enable_o,
    input wire [1:0] slew_rate_field_o,
    input wire       dominant_level_select_o,
    input wire       bus_pullup_o,
    input wire       irq_o,
    input wire       bus_level_i,
    input wire       wake_reset_o
);
    reg       hv_en_reg;
    reg       kill_reg;
    reg [3:0] lc_reg;
    reg [3:0] mask_reg;
    int       txd_low_reg;
    int       dom_run_reg;
    reg       long_dom_reg;
    wire      hot = low_overtemp_i || (hv_en_reg && high_voltage_i);
    wire      calm = !hot && op_mode_i == 2'h0;
    wire      lo_off = !low_driver_one_o && !low_driver_two_o;
    // conservative shadow: low drivers may be on only after a cool rewrite
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            hv_en_reg <= 1'h1;
            kill_reg <= 1'h1;
            lc_reg <= 4'h0;
            mask_reg <= 4'h0;
            txd_low_reg <= 0;
            dom_run_reg <= 0;
            long_dom_reg <= 1'h0;
        end else begin
            dom_run_reg <= (op_mode_i != 2'h0 && !bus_level_i) ? dom_run_reg + 1 : 0;
            if (op_mode_i == 2'h0) long_dom_reg <= 1'h0;
            else if (dom_run_reg >= WAKE_CYC) long_dom_reg <= 1'h1;
            if (wr_i && addr_i == 4'h0) hv_en_reg <= wdata_i[3];
            if (wr_i && addr_i == 4'h8) lc_reg <= wdata_i;
            if (wr_i && addr_i == 4'he) mask_reg <= wdata_i;
            if (!calm) kill_reg <= 1'h1;
            else if (wr_i && addr_i == 4'h8) kill_reg <= 1'h0;
            txd_low_reg <= txd_i ? 0 : txd_low_reg + 1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_en_one;
        wr_i && addr_i == 4'h8 && wdata_i[0] && !wdata_i[2] && calm;
    endsequence
    property p_busctl;
        logic [3:0] v;
        (wr_i && addr_i == 4'h4, v = wdata_i) |-> ##2 slew_rate_field_o == v[1:0] && dominant_level_select_o == v[3];
    endproperty
    AST_LOW_EN: assert property (s_en_one ##1 calm [*2] |-> low_driver_one_o)
        else $error("low driver one not on after enable write");
    AST_PWM: assert property ((!kill_reg && calm && lc_reg[2] && lc_reg[0] && $stable(lc_reg)
        && $stable(direct_modulation_input_i)) [*5] |-> low_driver_one_o == direct_modulation_input_i)
        else $error("low driver one does not follow modulation input");
    AST_LOW_OT: assert property (low_overtemp_i [*3] |-> lo_off)
        else $error("low drivers on during over-temperature");
    AST_LOW_SLEEP: assert property ((op_mode_i != 2'h0) [*3] |-> lo_off)
        else $error("low drivers on in low-power mode");
    AST_HV: assert property ((hv_en_reg && high_voltage_i) [*3] |-> lo_off && !high_driver_one_o
        && !high_driver_two_o)
        else $error("drivers on during high voltage");
    AST_LS_IRQ: assert property ((low_overtemp_i && mask_reg[2]) [*3] |-> irq_o)
        else $error("no irq for masked-in low over-temperature");
    AST_STUCK: assert property (txd_low_reg > STUCK_CYC + 2 |-> !tx_enable_o)
        else $error("transmitter on with transmit input stuck low");
    AST_BUSCTL: assert property (p_busctl)
        else $error("bus control outputs differ from written value");
    AST_RESET: assert property ($fell(rst_i) |-> slew_rate_field_o == 2'h1 && bus_pullup_o && !irq_o
        && lo_off)
        else $error("wrong values after reset");
    AST_WAKE_FILT: assert property ($rose(wake_reset_o) |-> long_dom_reg)
        else $error("wake reset without a long enough dominant level");
endmodule

bind dlfc_top dlfc_props #(.STUCK_CYC(STUCK_CYC), .WAKE_CYC(WAKE_CYC)) u_props (
    .sys_clk_i, .rst_i, .wr_i, .addr_i, .wdata_i, .op_mode_i, .high_voltage_i, .low_overtemp_i,
    .direct_modulation_input_i, .txd_i, .low_driver_one_o, .low_driver_two_o, .high_driver_one_o,
    .high_driver_two_o, .tx_enable_o, .slew_rate_field_o, .dominant_level_select_o, .bus_pullup_o, .irq_o,
    .bus_level_i, .wake_reset_o
);

//--- test/dlfc_bus_node.sv
module dlfc_bus_node (
    input  wire dominant_i,
    input  wire txd_i,
    input  wire tx_enable_i,
    output wire bus_level_o,
    output wire rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and line: any dominant driver beats the pull-up
    assign bus_level_o = !dominant_i && !(tx_enable_i && !txd_i);
    assign rxd_o = bus_level_o;
endmodule

//--- test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, high_voltage_i = 1'h0;
    logic       low_overtemp_i = 1'h0, direct_modulation_input_i = 1'h0, txd_i = 1'h1, dom = 1'h0;
    logic       bus_overcurrent_i = 1'h0, bus_overtemp_i = 1'h0;
    logic [3:0] addr_i = 4'h0, wdata_i = 4'h0, d;
    logic [1:0] op_mode_i = 2'h0, low_open_load_i = 2'h0, low_current_limit_i = 2'h0;
    wire  [3:0] rdata_o;
    wire  [1:0] slew_rate_field_o;
    wire        low_driver_one_o, low_driver_two_o, high_driver_one_o, high_driver_two_o, tx_enable_o;
    wire        dominant_level_select_o, bus_pullup_o, bus_wake_threshold_o, irq_o, wake_reset_o;
    wire        bus_level_i, rxd_i;
    int         err_total = 0, n_tests = 0;
    dlfc_top #(.STUCK_CYC(50), .WAKE_CYC(5)) DUT (
        .sys_clk_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .op_mode_i, .high_voltage_i,
        .low_overtemp_i, .high_overtemp_i(1'h0), .low_open_load_i, .low_current_limit_i,
        .bus_overcurrent_i, .bus_overtemp_i, .rx_short_i(1'h0), .direct_modulation_input_i,
        .txd_i, .rxd_i, .bus_level_i, .low_driver_one_o, .low_driver_two_o, .high_driver_one_o,
        .high_driver_two_o, .tx_enable_o, .slew_rate_field_o, .dominant_level_select_o, .bus_pullup_o,
        .bus_wake_threshold_o, .irq_o, .wake_reset_o
    );
    dlfc_bus_node u_node (.dominant_i(dom), .txd_i(txd_i), .tx_enable_i(tx_enable_o),
        .bus_level_o(bus_level_i), .rxd_o(rxd_i));
    wire [3:0] lows = {2'h0, low_driver_two_o, low_driver_one_o};
    wire [3:0] highs = {2'h0, high_driver_two_o, high_driver_one_o};
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] v);
        wr_i = 1'h1;
        addr_i = a;
        wdata_i = v;
        cyc(1);
        wr_i = 1'h0;
        cyc(2);
    endtask
    task automatic rd(input logic [3:0] a);
        rd_i = 1'h1;
        addr_i = a;
        cyc(1);
        rd_i = 1'h0;
        d = rdata_o;
        cyc(1);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_low;
        wr(4'h8, 4'h1);
        chk("lo en1", lows, 4'h1);
        wr(4'h8, 4'h2);
        chk("lo en2", lows, 4'h2);
        wr(4'h8, 4'h5);
        direct_modulation_input_i = 1'h1;
        cyc(4);
        chk("pwm hi", lows, 4'h1);
        direct_modulation_input_i = 1'h0;
        cyc(4);
        chk("pwm lo", lows, 4'h0);
        low_open_load_i = 2'h1;
        low_current_limit_i = 2'h2;
        rd(4'h9);
        chk("lo stat", d, 4'h6);
        low_open_load_i = 2'h0;
        low_current_limit_i = 2'h0;
        $display("low side test done");
    endtask
    task automatic t_ot;
        wr(4'h8, 4'h3);
        low_overtemp_i = 1'h1;
        cyc(3);
        chk("ot off", lows, 4'h0);
        chk("ot unmasked", {3'h0, irq_o}, 4'h0);
        wr(4'he, 4'h4);
        chk("ot masked", {3'h0, irq_o}, 4'h1);
        rd(4'hf);
        chk("ot src", {1'h0, d[2], 2'h0}, 4'h4);
        low_overtemp_i = 1'h0;
        cyc(3);
        chk("ot latch", lows, 4'h0);
        wr(4'h8, 4'h3);
        chk("ot rewrite", lows, 4'h3);
        wr(4'he, 4'h0);
        $display("over-temperature test done");
    endtask
    task automatic t_hv;
        wr(4'h6, 4'h3);
        high_voltage_i = 1'h1;
        cyc(3);
        chk("hv hi", highs, 4'h0);
        chk("hv lo", lows, 4'h0);
        high_voltage_i = 1'h0;
        cyc(3);
        chk("hv latch", highs, 4'h0);
        wr(4'h6, 4'h3);
        wr(4'h8, 4'h3);
        chk("hv hi back", highs, 4'h3);
        chk("hv lo back", lows, 4'h3);
        wr(4'h0, 4'h8);
        op_mode_i = 2'h2;
        cyc(3);
        chk("sleep lo", lows, 4'h0);
        chk("sleep hi", highs, 4'h3);
        chk("sleep pu", {3'h0, bus_pullup_o}, 4'h0);
        chk("sleep thr", {3'h0, bus_wake_threshold_o}, 4'h0);
        op_mode_i = 2'h0;
        wr(4'h0, 4'hc);
        $display("high voltage and sleep test done");
    endtask
    task automatic t_stuck;
        for (int i = 0; i < 3; i++) begin
            wr(4'h4, {i[0], 1'h0, i[1:0]});
            chk("slew", {dominant_level_select_o, 1'h0, slew_rate_field_o}, {i[0], 1'h0, i[1:0]});
        end
        wr(4'h4, 4'h5);
        chk("rx only", {3'h0, tx_enable_o}, 4'h0);
        wr(4'h4, 4'h1);
        wr(4'he, 4'h2);
        txd_i = 1'h0;
        cyc(60);
        chk("stuck tx", {3'h0, tx_enable_o}, 4'h0);
        chk("stuck irq", {3'h0, irq_o}, 4'h1);
        txd_i = 1'h1;
        cyc(3);
        rd(4'h5);
        chk("stuck flag", d, 4'h4);
        wr(4'h4, 4'h1);
        chk("tx back", {3'h0, tx_enable_o}, 4'h1);
        rd(4'h5);
        chk("flag clear", d, 4'h0);
        wr(4'he, 4'h0);
        $display("transmit stuck test done");
    endtask
    task automatic t_lin;
        wr(4'he, 4'h2);
        bus_overcurrent_i = 1'h1;
        bus_overtemp_i = 1'h1;
        cyc(3);
        chk("lin irq", {3'h0, irq_o}, 4'h1);
        chk("ot tx", {3'h0, tx_enable_o}, 4'h0);
        bus_overcurrent_i = 1'h0;
        bus_overtemp_i = 1'h0;
        cyc(2);
        rd(4'h5);
        chk("oc ot flags", d, 4'h3);
        wr(4'h4, 4'h1);
        chk("ot tx back", {3'h0, tx_enable_o}, 4'h1);
        rd(4'h5);
        chk("oc ot clear", d, 4'h0);
        wr(4'he, 4'h0);
        $display("bus fault test done");
    endtask
    task automatic t_wake;
        op_mode_i = 2'h1;
        dom = 1'h1;
        cyc(2);
        dom = 1'h0;
        cyc(4);
        chk("short pulse", {3'h0, irq_o}, 4'h0);
        dom = 1'h1;
        cyc(10);
        dom = 1'h0;
        cyc(4);
        chk("stop wake", {3'h0, irq_o}, 4'h1);
        rd(4'hf);
        chk("wake src", {3'h0, d[0]}, 4'h1);
        op_mode_i = 2'h2;
        dom = 1'h1;
        cyc(10);
        dom = 1'h0;
        cyc(4);
        chk("sleep wake", {3'h0, wake_reset_o}, 4'h1);
        $display("wake test done");
    endtask
    initial begin
        #100us;
        chk("timeout", 4'h0, 4'h1);
        complete_run;
    end
    initial begin
        cyc(20);
        rst_i = 1'h0;
        chk("rst state", {slew_rate_field_o, bus_pullup_o, irq_o}, 4'h6);
        cyc(3);
        t_low;
        t_ot;
        t_hv;
        t_stuck;
        t_lin;
        t_wake;
        complete_run;
    end
endmodule
